// ---- common/csc_pkg.sv ----
// Notes on behaviour
// - 224 counters, 24 bits each, all cleared on reset.
// - counters add one per event, wrap to zero, overflow request if unmasked.
// - software may preload any counter with a starting value.
// - per input port: all or user cells, idle, unassigned, uncorrected header errors.
// - per transmit link: all cells, idle or user, stuff cells, control cells.
// - per receive link, once enabled: all or stuff, idle or user, violations, header errors.
// - receive user cell count also counts received stuff cells.
// - read: select, write read code, then holding registers show the counter.
// - holding registers keep the captured value until the next read code or a software write to them.
// - preload: fill holding registers, select, write code loads the counter.
// - enable code unmasks the selected overflow request, disable code masks it.
// - latching mode copies all counters to shadows at once, pin or software trigger.
// - pin trigger used directly or once per 8000 pin pulses.
// - latching mode counters are 16 bits and restart from zero after each latch.
// - input group 7 all-cells counter keeps accumulating across latches.
// - per-link overflow status is live and clears when the counter is masked.
package csc_pkg;
  localparam int NUM_CNT   = 224;
  localparam int NUM_IN    = 24;
  localparam int NUM_LINK  = 16;
  localparam int NUM_GRP   = 8;
  localparam int CNT_W     = 24;
  localparam int LATCH_W   = 16;
  localparam int IDX_W     = 8;
  // storage layout: tx link*4+kind, input 64+kind*24+port, rx 160+link*4+kind
  localparam int TX_BASE   = 0;
  localparam int IN_BASE   = 64;
  localparam int RX_BASE   = 160;
  // selection value is 0x100 plus storage index for tx, 0x120 plus storage index above the gap; the block 0x140..0x15F is unused
  localparam logic [15:0] SEL_BASE    = 16'h0100;
  localparam logic [15:0] SEL_GAP_LO  = 16'h0140;
  localparam logic [15:0] SEL_RX_LO   = 16'h0160;
  localparam logic [15:0] SEL_END     = 16'h0200;
  localparam logic [15:0] SEL_EXEMPT  = 16'h0177;
  localparam int          EXEMPT_IDX  = 87;
  // register indices, byte address is four times the index
  localparam logic [10:0] IDX_XFER_CMD   = 11'h40F;
  localparam logic [10:0] IDX_HOLD_UPPER = 11'h430;
  localparam logic [10:0] IDX_HOLD_LOWER = 11'h431;
  localparam logic [10:0] IDX_SELECT     = 11'h432;
  localparam logic [10:0] IDX_IRQ_STAT   = 11'h460;
  localparam logic [10:0] IDX_IRQ_CLR    = 11'h461;
  localparam logic [10:0] IDX_IRQ_EN     = 11'h462;
  localparam logic [10:0] IDX_LINK_OVF   = 11'h463;
  localparam logic [10:0] IDX_GRP_OVF    = 11'h464;
  // transfer command: low byte is the code, upper bits hold configuration
  localparam logic [2:0] OP_READ   = 3'h5;
  localparam logic [2:0] OP_WRITE  = 3'h1;
  localparam logic [2:0] OP_IRQ    = 3'h2;
  localparam int CFG_LATCH_EN  = 8;
  localparam int CFG_PIN_SRC   = 9;
  localparam int CFG_DIV8000   = 10;
  localparam int CFG_SW_LATCH  = 11;
  localparam int CFG_IN_USER   = 12;
  localparam int CFG_TX_USER   = 13;
  localparam int CFG_RX_STUFF  = 14;
  localparam int CFG_RX_USER   = 15;
  localparam logic [15:0] CFG_MASK   = 16'hF700;
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  // interrupt status bits
  localparam int IRQ_OVF   = 0;
  localparam int IRQ_LATCH = 1;
  localparam int IRQ_W     = 2;
  localparam int DIV_COUNT = 8000;
  localparam int DIV_W     = 13;
endpackage : csc_pkg

// ---- rtl/csc_latch_trig.sv ----
// frame pulse pin to latch trigger: synchronise, detect edge, optional divide
module csc_latch_trig
  import csc_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // pin and mode
  input  wire logic frame_pulse_input,
  input  wire logic divide_en,
  // trigger
  output logic      pin_latch
);
  logic             sync_a;
  logic             sync_b;
  logic             sync_c;
  logic [DIV_W-1:0] pulse_cnt;
  logic             edge_seen;

  // two flops before anything looks at the pin
  always_ff @(posedge clock) begin
    if (srst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= frame_pulse_input;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign edge_seen = sync_b & ~sync_c;

  // one latch per pulse, or per 8000 pulses (8 kHz frame gives one second)
  always_ff @(posedge clock) begin
    if (srst) begin
      pulse_cnt <= '0;
      pin_latch <= 1'b0;
    end else begin
      pin_latch <= 1'b0;
      if (!divide_en) begin
        pulse_cnt <= '0;
        pin_latch <= edge_seen;
      end else if (edge_seen) begin
        if (pulse_cnt == DIV_W'(DIV_COUNT - 1)) begin
          pulse_cnt <= '0;
          pin_latch <= 1'b1;
        end else begin
          pulse_cnt <= pulse_cnt + 1'b1;
        end
      end
    end
  end
endmodule : csc_latch_trig

// ---- rtl/csc_counter_bank.sv ----
// statistics counter bank with wishbone register access
//
// Design decision made here: the Wishbone slave port.
module csc_counter_bank
  import csc_pkg::*;
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                srst,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [12:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // latch trigger pin
  input  wire logic                frame_pulse_input,
  // input port events, one bit per port
  input  wire logic [NUM_IN-1:0]   in_cell,
  input  wire logic [NUM_IN-1:0]   in_user_cell,
  input  wire logic [NUM_IN-1:0]   in_idle_cell,
  input  wire logic [NUM_IN-1:0]   in_unassigned_cell,
  input  wire logic [NUM_IN-1:0]   in_hec_error,
  // transmit link events
  input  wire logic [NUM_LINK-1:0] tx_cell,
  input  wire logic [NUM_LINK-1:0] tx_idle_cell,
  input  wire logic [NUM_LINK-1:0] tx_user_cell,
  input  wire logic [NUM_LINK-1:0] tx_stuff_cell,
  input  wire logic [NUM_LINK-1:0] tx_icp_cell,
  // receive link events
  input  wire logic [NUM_LINK-1:0] rx_port_enable,
  input  wire logic [NUM_LINK-1:0] rx_cell,
  input  wire logic [NUM_LINK-1:0] rx_stuff_event,
  input  wire logic [NUM_LINK-1:0] rx_idle_cell,
  input  wire logic [NUM_LINK-1:0] rx_user_cell,
  input  wire logic [NUM_LINK-1:0] rx_stuff_cell,
  input  wire logic [NUM_LINK-1:0] rx_icp_violation,
  input  wire logic [NUM_LINK-1:0] rx_hec_error,
  // interrupt
  output logic                     irq
);
  logic [CNT_W-1:0]    cnt     [NUM_CNT];
  logic [LATCH_W-1:0]  shadow  [NUM_CNT];
  logic [NUM_CNT-1:0]  evt;
  logic [NUM_CNT-1:0]  irq_en;
  logic [NUM_CNT-1:0]  ovf;
  logic [NUM_CNT-1:0]  wrap;
  logic [15:0]         cfg;
  logic [7:0]          hold_upper;
  logic [15:0]         hold_lower;
  logic [15:0]         select;
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    irq_enable;
  logic [NUM_LINK-1:0] link_ovf;
  logic [NUM_GRP-1:0]  grp_ovf;
  logic                wb_req;
  logic                wr_acc;
  logic [10:0]         reg_idx;
  logic [7:0]          cmd_code;
  logic                cmd_wr;
  logic                do_read;
  logic                do_load;
  logic                do_irq_on;
  logic                do_irq_off;
  logic                sel_valid;
  logic [IDX_W-1:0]    sel_idx;
  logic                pin_latch;
  logic                latch_now;
  logic                latch_mode;
  logic [CNT_W-1:0]    sel_value;
  logic [31:0]         next_rdata;

  // bus decode: a request is answered once, one cycle after it appears
  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_acc   = wb_req & wb_we_i;
  assign reg_idx  = wb_adr_i[12:2];
  assign cmd_wr   = wr_acc & (reg_idx == IDX_XFER_CMD) & wb_sel_i[0];
  assign cmd_code = wb_dat_i[7:0];
  // the code field ignores the bits shown as don't care
  assign do_read    = cmd_wr & (cmd_code[2:0] == OP_READ) & (cmd_code[5:4] == 2'b00)
                      & ~cmd_code[7];
  assign do_load    = cmd_wr & (cmd_code[2:0] == OP_WRITE) & (cmd_code[5:4] == 2'b00)
                      & ~cmd_code[7] & sel_valid;
  assign do_irq_on  = cmd_wr & (cmd_code[4:0] == 5'h0A) & (cmd_code[7:5] == 3'b000)
                      & sel_valid;
  assign do_irq_off = cmd_wr & (cmd_code[4:0] == 5'h02) & sel_valid;
  assign latch_mode = cfg[CFG_LATCH_EN];

  // selection to storage index, the gap between tx and input blocks is unmapped
  always_comb begin
    sel_valid = 1'b0;
    sel_idx   = '0;
    if (select >= SEL_BASE && select < SEL_END && !(select >= SEL_GAP_LO
        && select < SEL_RX_LO)) begin
      sel_valid = 1'b1;
      if (select < SEL_GAP_LO) begin
        sel_idx = select[IDX_W-1:0];
      end else begin
        sel_idx = IDX_W'(select[IDX_W-1:0] - 8'h20);
      end
    end
  end

  // latch source: pin (optionally divided) or the software latch bit
  csc_latch_trig u_trig (
    .clock             (clock),
    .srst              (srst),
    .frame_pulse_input (frame_pulse_input),
    .divide_en         (cfg[CFG_DIV8000]),
    .pin_latch         (pin_latch)
  );

  // the software latch lives in the config byte, so it must not wait for a code byte
  assign latch_now = latch_mode & ((cfg[CFG_PIN_SRC] & pin_latch)
                     | (wr_acc & (reg_idx == IDX_XFER_CMD) & wb_sel_i[1]
                     & wb_dat_i[CFG_SW_LATCH]));

  // event routing per counter
  genvar g;
  generate
    for (g = 0; g < NUM_LINK; g++) begin : g_link
      assign evt[TX_BASE+g*4+0] = tx_cell[g];
      assign evt[TX_BASE+g*4+1] = cfg[CFG_TX_USER] ? tx_user_cell[g] : tx_idle_cell[g];
      assign evt[TX_BASE+g*4+2] = tx_stuff_cell[g];
      assign evt[TX_BASE+g*4+3] = tx_icp_cell[g];
      // receive counters only run while the port is enabled
      assign evt[RX_BASE+g*4+0] = rx_port_enable[g] & (cfg[CFG_RX_STUFF] ? rx_stuff_event[g]
                                  : rx_cell[g]);
      assign evt[RX_BASE+g*4+1] = rx_port_enable[g] & (cfg[CFG_RX_USER]
                                  ? (rx_user_cell[g] | rx_stuff_cell[g])
                                  : rx_idle_cell[g]);
      assign evt[RX_BASE+g*4+2] = rx_port_enable[g] & rx_icp_violation[g];
      assign evt[RX_BASE+g*4+3] = rx_port_enable[g] & rx_hec_error[g];
      assign link_ovf[g] = |ovf[TX_BASE+g*4 +: 4] | |ovf[RX_BASE+g*4 +: 4]
                           | ovf[IN_BASE+g] | ovf[IN_BASE+NUM_IN+g]
                           | ovf[IN_BASE+2*NUM_IN+g] | ovf[IN_BASE+3*NUM_IN+g];
    end
    for (g = 0; g < NUM_IN; g++) begin : g_in
      assign evt[IN_BASE+g]          = cfg[CFG_IN_USER] ? in_user_cell[g] : in_cell[g];
      assign evt[IN_BASE+NUM_IN+g]   = in_idle_cell[g];
      assign evt[IN_BASE+2*NUM_IN+g] = in_unassigned_cell[g];
      assign evt[IN_BASE+3*NUM_IN+g] = in_hec_error[g];
    end
    for (g = 0; g < NUM_GRP; g++) begin : g_grp
      assign grp_ovf[g] = ovf[IN_BASE+NUM_LINK+g] | ovf[IN_BASE+NUM_IN+NUM_LINK+g]
                          | ovf[IN_BASE+2*NUM_IN+NUM_LINK+g]
                          | ovf[IN_BASE+3*NUM_IN+NUM_LINK+g];
    end
    // one counter per entry: load beats latch beats increment in the same cycle
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      localparam bit EXEMPT = (g == EXEMPT_IDX);
      logic load_me;
      assign load_me = do_load & (sel_idx == IDX_W'(g));
      // 16-bit wrap point in latching mode, except the accumulating one
      assign wrap[g] = evt[g] & (latch_mode & !EXEMPT ? (cnt[g][LATCH_W-1:0] == 16'hFFFF)
                       : (cnt[g] == 24'hFFFFFF));
      always_ff @(posedge clock) begin
        if (srst) begin
          cnt[g] <= '0;
        end else if (load_me) begin
          cnt[g] <= {hold_upper, hold_lower};
        end else if (latch_now && !EXEMPT) begin
          cnt[g] <= {23'h000000, evt[g]};
        end else if (wrap[g]) begin
          cnt[g] <= '0;
        end else if (evt[g]) begin
          cnt[g] <= cnt[g] + 1'b1;
        end
      end
      // shadow copy of every counter in the same cycle
      always_ff @(posedge clock) begin
        if (srst) begin
          shadow[g] <= '0;
        end else if (latch_now) begin
          shadow[g] <= cnt[g][LATCH_W-1:0];
        end
      end
      // mask bit and live overflow status; masking clears the status
      always_ff @(posedge clock) begin
        if (srst) begin
          irq_en[g] <= 1'b0;
          ovf[g]    <= 1'b0;
        end else begin
          if (sel_idx == IDX_W'(g) && do_irq_on) begin
            irq_en[g] <= 1'b1;
          end else if (sel_idx == IDX_W'(g) && do_irq_off) begin
            irq_en[g] <= 1'b0;
          end
          if (!irq_en[g] || (sel_idx == IDX_W'(g) && do_irq_off)) begin
            ovf[g] <= 1'b0;
          end else if (wrap[g]) begin
            ovf[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // value presented to a read: the shadow when latching, except the accumulating one, the live count otherwise
  always_comb begin
    sel_value = '0;
    if (sel_valid) begin
      if (latch_mode && sel_idx != IDX_W'(EXEMPT_IDX)) begin
        sel_value = {8'h00, shadow[sel_idx]};
      end else begin
        sel_value = cnt[sel_idx];
      end
    end
  end

  // software registers; a read code overwrites the holding pair
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg        <= CFG_RESET;
      hold_upper <= '0;
      hold_lower <= '0;
      select     <= '0;
    end else begin
      if (do_read) begin
        hold_upper <= sel_value[23:16];
        hold_lower <= sel_value[15:0];
      end else if (wr_acc && reg_idx == IDX_HOLD_UPPER && wb_sel_i[0]) begin
        hold_upper <= wb_dat_i[7:0];
      end else if (wr_acc && reg_idx == IDX_HOLD_LOWER) begin
        if (wb_sel_i[0]) hold_lower[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) hold_lower[15:8] <= wb_dat_i[15:8];
      end
      if (wr_acc && reg_idx == IDX_SELECT) begin
        if (wb_sel_i[0]) select[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) select[15:8] <= wb_dat_i[15:8];
      end
      // software latch bit is a command and is not stored
      if (wr_acc && reg_idx == IDX_XFER_CMD && wb_sel_i[1]) begin
        cfg <= wb_dat_i[15:0] & CFG_MASK;
      end
    end
  end

  // sticky interrupt status; a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      if (wr_acc && reg_idx == IDX_IRQ_EN && wb_sel_i[0]) begin
        irq_enable <= wb_dat_i[IRQ_W-1:0];
      end
      irq_status[IRQ_OVF]   <= (|(wrap & irq_en)) | (irq_status[IRQ_OVF]
                               & ~(wr_acc && reg_idx == IDX_IRQ_CLR && wb_sel_i[0]
                               && wb_dat_i[IRQ_OVF]));
      irq_status[IRQ_LATCH] <= latch_now | (irq_status[IRQ_LATCH]
                               & ~(wr_acc && reg_idx == IDX_IRQ_CLR && wb_sel_i[0]
                               && wb_dat_i[IRQ_LATCH]));
    end
  end

  // interrupt output is registered so it comes straight from a flop
  always_ff @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // read data mux; unmapped and write-only words read as zero
  always_comb begin
    next_rdata = '0;
    case (reg_idx)
      IDX_XFER_CMD:   next_rdata = {16'h0000, cfg};
      IDX_HOLD_UPPER: next_rdata = {24'h000000, hold_upper};
      IDX_HOLD_LOWER: next_rdata = {16'h0000, hold_lower};
      IDX_SELECT:     next_rdata = {16'h0000, select};
      IDX_IRQ_STAT:   next_rdata = {30'h00000000, irq_status};
      IDX_IRQ_EN:     next_rdata = {30'h00000000, irq_enable};
      IDX_LINK_OVF:   next_rdata = {16'h0000, link_ovf};
      IDX_GRP_OVF:    next_rdata = {24'h000000, grp_ovf};
      default:        next_rdata = '0;
    endcase
  end

  // ack every request after one cycle, mapped or not, and drop it the next
  always_ff @(posedge clock) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end
endmodule : csc_counter_bank

// ---- sim/csc_counter_bank_properties.sv ----
// watches the register bus and interrupt pin of the counter bank
module csc_counter_bank_properties
  import csc_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // wishbone slave side
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [12:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // interrupt
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // register index; the two low address bits are ignored
  logic [10:0] idx;
  logic        mapped;
  assign idx    = wb_adr_i[12:2];
  assign mapped = idx inside {IDX_XFER_CMD, IDX_HOLD_UPPER, IDX_HOLD_LOWER, IDX_SELECT,
                              IDX_IRQ_STAT, IDX_IRQ_CLR, IDX_IRQ_EN, IDX_LINK_OVF, IDX_GRP_OVF};

  // bus steps: a fresh request, and the answer to a read
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_ack_s;
    wb_ack_o && !wb_we_i;
  endsequence

  req_ack_a: assert property (req_s |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  rdata_hold_a: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o))
    else $error("read data moved outside a read answer");
  unmapped_zero_a: assert property (rd_ack_s ##0 !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  hold_width_a: assert property (rd_ack_s ##0 (idx == IDX_HOLD_UPPER) |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper holding register too wide");
  cmd_code_zero_a: assert property (rd_ack_s ##0 (idx == IDX_XFER_CMD)
    |-> {wb_dat_o[31:16], wb_dat_o[11], wb_dat_o[7:0]} == 25'h0)
    else $error("command code read back");
  irq_mask_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && idx == IDX_IRQ_EN
    && wb_dat_i[1:0] == 2'b00 |=> !irq)
    else $error("irq high with all sources disabled");
  irq_reset_a: assert property ($fell(srst) |-> !irq && !wb_ack_o)
    else $error("outputs active after reset");
endmodule : csc_counter_bank_properties

bind csc_counter_bank csc_counter_bank_properties csc_counter_bank_properties_inst (
  .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq(irq));

// ---- sim/csc_counter_bank_tb.sv ----
// register-level bench for the counter bank
module csc_counter_bank_tb
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, fp;
  logic [12:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [311:0] ev;  // every event strobe in port order
  logic [15:0] rx_en;
  logic [23:0] v;
  int          errors, n_checks;
  // one counter of each kind on port or link 5, by strobe offset and selection value
  int          evo[12] = '{0, 48, 72, 96, 120, 136, 168, 184, 200, 232, 280, 296};
  logic [15:0] sl[12] = '{16'h0165, 16'h017D, 16'h0195, 16'h01AD, 16'h0114, 16'h0115,
                          16'h0116, 16'h0117, 16'h01D4, 16'h01D5, 16'h01D6, 16'h01D7};
  logic [10:0] regs[7] = '{IDX_XFER_CMD, IDX_HOLD_UPPER, IDX_HOLD_LOWER, IDX_SELECT,
                           IDX_IRQ_STAT, IDX_IRQ_EN, 11'h400};
  int          ul[4] = '{0, 5, 8, 9};
  int          ue[4] = '{2, 3, 2, 3};

  // 125 MHz system clock
  always #4 clock = ~clock;

  csc_counter_bank csc_counter_bank_inst (
    .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .frame_pulse_input(fp), .in_cell(ev[23:0]),
    .in_user_cell(ev[47:24]), .in_idle_cell(ev[71:48]), .in_unassigned_cell(ev[95:72]),
    .in_hec_error(ev[119:96]), .tx_cell(ev[135:120]), .tx_idle_cell(ev[151:136]),
    .tx_user_cell(ev[167:152]), .tx_stuff_cell(ev[183:168]), .tx_icp_cell(ev[199:184]),
    .rx_port_enable(rx_en), .rx_cell(ev[215:200]), .rx_stuff_event(ev[231:216]),
    .rx_idle_cell(ev[247:232]), .rx_user_cell(ev[263:248]), .rx_stuff_cell(ev[279:264]),
    .rx_icp_violation(ev[295:280]), .rx_hec_error(ev[311:296]), .irq(irq));

  task finish_test;
    $display("comparisons %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; held until ack, then one idle cycle
  task wb_io(input logic we, input logic [10:0] idx, input logic [3:0] sel,
             input logic [15:0] wd);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {16'h0000, wd};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 16);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      finish_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb_io

  task rd_chk(input logic [10:0] idx, input logic [31:0] exp);
    wb_io(1'b0, idx, 4'h3, 16'h0000);
    chk(rd, exp);
  endtask : rd_chk

  // select, read code, then both holding registers
  task cnt_rd(input logic [15:0] s, input logic [23:0] exp);
    wb_io(1'b1, IDX_SELECT, 4'h3, s);
    wb_io(1'b1, IDX_XFER_CMD, 4'h1, 16'h0005);
    wb_io(1'b0, IDX_HOLD_UPPER, 4'h3, 16'h0000);
    v[23:16] = rd[7:0];
    wb_io(1'b0, IDX_HOLD_LOWER, 4'h3, 16'h0000);
    v[15:0] = rd[15:0];
    chk({8'h00, v}, {8'h00, exp});
  endtask : cnt_rd

  task cnt_wr(input logic [15:0] s, input logic [23:0] val);
    wb_io(1'b1, IDX_HOLD_UPPER, 4'h3, {8'h00, val[23:16]});
    wb_io(1'b1, IDX_HOLD_LOWER, 4'h3, val[15:0]);
    wb_io(1'b1, IDX_SELECT, 4'h3, s);
    wb_io(1'b1, IDX_XFER_CMD, 4'h1, 16'h0001);
  endtask : cnt_wr

  // one-cycle strobes with a gap, so each is a separate event
  task pulse(input int b, input int n);
    repeat (n) begin
      ev[b] <= 1'b1;
      @(posedge clock);
      ev[b] <= 1'b0;
      @(posedge clock);
    end
  endtask : pulse

  task pin(input int n);
    repeat (n) begin
      fp <= 1'b1;
      repeat (2) @(posedge clock);
      fp <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask : pin

  initial begin
    srst = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = '0;
    wb_sel_i = '0; wb_dat_i = '0; ev = '0; rx_en = '0; fp = 1'b0; errors = 0; n_checks = 0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 12; i++) cnt_rd(sl[i], 24'h0);
    $display("test reset done");
    // rx link 5 disabled at first: that strobe must be lost
    pulse(205, 1);
    rx_en <= 16'hFFFF;
    for (int i = 0; i < 12; i++) pulse(evo[i] + 5, i + 1);
    for (int i = 0; i < 12; i++) cnt_rd(sl[i], 24'(i + 1));
    pulse(301, 1);
    rd_chk(IDX_HOLD_LOWER, 32'd12);
    cnt_rd(16'h0150, 24'h0);
    rd_chk(IDX_SELECT, 32'h0150);
    wb_io(1'b1, IDX_HOLD_UPPER, 4'h3, 16'h12AB);
    rd_chk(IDX_HOLD_UPPER, 32'h00AB);
    wb_io(1'b1, 11'h400, 4'h3, 16'hFFFF);
    rd_chk(11'h400, 32'h0);
    $display("test counting done");
    // user-cell and rx stuff selections, from a preloaded base
    wb_io(1'b1, IDX_XFER_CMD, 4'h2, 16'hF000);
    foreach (ul[i]) cnt_wr(sl[ul[i]], 24'h5A0000);
    pulse(5, 1); pulse(29, 2); pulse(141, 1); pulse(157, 3);
    pulse(205, 1); pulse(221, 2); pulse(253, 1); pulse(269, 2);
    foreach (ul[i]) cnt_rd(sl[ul[i]], 24'h5A0000 + 24'(ue[i]));
    wb_io(1'b1, IDX_XFER_CMD, 4'h2, 16'h0000);
    $display("test user modes done");
    // wrap and overflow interrupt on tx link 5 all-cells
    cnt_wr(sl[4], 24'hFFFFFE);
    wb_io(1'b1, IDX_XFER_CMD, 4'h1, 16'h000A);
    wb_io(1'b1, IDX_IRQ_EN, 4'h3, 16'h0001);
    pulse(125, 1);
    cnt_rd(sl[4], 24'hFFFFFF);
    chk({31'h0, irq}, 32'h0);
    pulse(125, 1);
    rd_chk(IDX_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd_chk(IDX_LINK_OVF, 32'h0020);
    cnt_rd(sl[4], 24'h0);
    wb_io(1'b1, IDX_IRQ_EN, 4'h3, 16'h0000);
    chk({31'h0, irq}, 32'h0);
    wb_io(1'b1, IDX_XFER_CMD, 4'h1, 16'h0002);
    rd_chk(IDX_LINK_OVF, 32'h0);
    rd_chk(IDX_IRQ_STAT, 32'h1);
    wb_io(1'b1, IDX_IRQ_CLR, 4'h3, 16'h0001);
    rd_chk(IDX_IRQ_STAT, 32'h0);
    cnt_wr(sl[4], 24'hFFFFFF);
    pulse(125, 1);
    rd_chk(IDX_IRQ_STAT, 32'h0);
    $display("test overflow done");
    // latching by software command; preloads only before the mode is on
    cnt_wr(sl[4], 24'h000003);
    cnt_wr(16'h0177, 24'h00000A);
    wb_io(1'b1, IDX_XFER_CMD, 4'h2, 16'h0100);
    pulse(125, 2); pulse(23, 2);
    wb_io(1'b1, IDX_XFER_CMD, 4'h2, 16'h0900);
    cnt_rd(sl[4], 24'h5);
    cnt_rd(16'h0177, 24'hC);
    pulse(125, 2); pulse(23, 2);
    cnt_rd(sl[4], 24'h5);
    wb_io(1'b1, IDX_XFER_CMD, 4'h2, 16'h0900);
    cnt_rd(sl[4], 24'h2);
    cnt_rd(16'h0177, 24'hE);
    // pin trigger, direct and then divided; settle time covers the synchroniser
    wb_io(1'b1, IDX_XFER_CMD, 4'h2, 16'h0300);
    rd_chk(IDX_XFER_CMD, 32'h0300);
    pulse(125, 3);
    pin(1);
    repeat (8) @(posedge clock);
    cnt_rd(sl[4], 24'h3);
    wb_io(1'b1, IDX_XFER_CMD, 4'h2, 16'h0700);
    pulse(125, 4);
    pin(7990);
    cnt_rd(sl[4], 24'h3);
    pin(10);
    repeat (8) @(posedge clock);
    cnt_rd(sl[4], 24'h4);
    wb_io(1'b1, IDX_XFER_CMD, 4'h2, 16'h0000);
    $display("test latching done");
    finish_test();
  end
endmodule : csc_counter_bank_tb
